/* File: iect_timer.sv */
// Timer channel: 16-bit up counter with interval and event count modes.
// Assumes event_input_pin is synchronous to aclk apart from the sync stage.
//
// Notes on behaviour
// [RQ1] Interval period is compare zero plus one
// [RQ2] Compare one still buffered and matched
// [RQ3] Compare zero 0000H: match every clock
// [RQ4] FFFFH limit wraps without overflow
// [RQ5] Compare zero write reaches buffer at once
// [RQ6] Software stops counter before lowering compare
// [RQ7] Compare one in range toggles output one
// [RQ8] Compare one above zero never matches
// [RQ9] First external edge clears counter, starts
// [RQ10] Both compares 0001H: output one halves
// [RQ11] Software sets event enable only when needed
// [RQ12] Event mode run clears counter, loads buffer
// [RQ13] Event mode match clears, raises request
// [RQ14] Outputs frozen in event count mode
// [RQ15] Software never sets zero compare in event mode
// [RQ16] Event mode compare one still matches
// [RQ17] Count register reads the live counter while running, 0000H when stopped
// [RQ18] Interval start clears, toggles, loads buffer
// [RQ19] Interval match clears, toggles, requests
// [RQ20] Mode field 000 selects interval mode
// [RQ21] External edges synchronised, counted once
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`default_nettype none

module iect_timer #(
    parameter int CLK_DIV = iect_pkg::CLK_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic event_input_pin,
    output logic output_zero,
    output logic output_one,
    output logic zero_match_request,
    output logic one_match_request,
    output logic overflow_request
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [5:0] ctrl;
    logic [15:0] compare_reg_zero;
    logic [15:0] compare_reg_one;
    logic [15:0] compare_buffer_zero;
    logic [15:0] compare_buffer_one;
    logic [15:0] count;
    logic started;
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic run_bit;
    logic external_event_enable;
    logic interval_mode;
    logic event_mode;
    logic [2:0] mode_field;
    localparam logic [15:0] CNT0 = iect_pkg::CNT_ZERO;

    assign run_bit = ctrl[iect_pkg::RUN_POS];
    assign mode_field = ctrl[iect_pkg::MODE_LSB +: 3];
    assign external_event_enable = ctrl[iect_pkg::EEE_POS];
    assign interval_mode = (mode_field == iect_pkg::IECT_INTERVAL); // [RQ20]
    assign event_mode = (mode_field == iect_pkg::IECT_EVENT);

    // Decoder of mapped offsets, shared by read and write paths
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == iect_pkg::CTRL_OFS) || (a == iect_pkg::CMP0_OFS) ||
            (a == iect_pkg::CMP1_OFS) || (a == iect_pkg::COUNT_OFS) ||
            (a == iect_pkg::STATUS_OFS);
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
        input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign wr_fire = aw_full && w_full && !s_axi_bvalid;

    // Address and data are held until both have arrived
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= iect_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(aw_addr) ? iect_pkg::RESP_OKAY : iect_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Software-written registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl <= iect_pkg::CTRL_RST;
            compare_reg_zero <= iect_pkg::CMP_RST;
            compare_reg_one <= iect_pkg::CMP_RST;
        end
        else if (wr_fire)
        begin
            if (aw_addr == iect_pkg::CTRL_OFS && w_strb[0])
                ctrl <= w_data[5:0];
            if (aw_addr == iect_pkg::CMP0_OFS)
                compare_reg_zero <= merge16(compare_reg_zero, w_data, w_strb);
            if (aw_addr == iect_pkg::CMP1_OFS)
                compare_reg_one <= merge16(compare_reg_one, w_data, w_strb);
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    // Count register shows the live count while running, zero when stopped
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= iect_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= is_mapped(s_axi_araddr) ? iect_pkg::RESP_OKAY : iect_pkg::RESP_SLVERR;
            unique case (s_axi_araddr)
                iect_pkg::CTRL_OFS: s_axi_rdata <= {26'h0000000, ctrl};
                iect_pkg::CMP0_OFS: s_axi_rdata <= {16'h0000, compare_reg_zero};
                iect_pkg::CMP1_OFS: s_axi_rdata <= {16'h0000, compare_reg_one};
                iect_pkg::COUNT_OFS: s_axi_rdata <= {16'h0000, run_bit ? count : CNT0}; // [RQ17]
                iect_pkg::STATUS_OFS: s_axi_rdata <= {30'h00000000, started, 1'b0};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ----------------------------------------
    // Count clock sources
    // ----------------------------------------
    logic [2:0] pin_sync;
    logic [15:0] div_cnt;
    logic int_tick;
    logic ev_edge;
    logic tick;

    // Two-stage synchroniser, then a third stage for edge detection
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pin_sync <= 3'h0;
        else
            pin_sync <= {pin_sync[1:0], event_input_pin}; // [RQ21]
    end

    // One pulse per valid edge, rising or falling as selected
    assign ev_edge = ctrl[iect_pkg::FALL_POS] ? (pin_sync[2] && !pin_sync[1]) :
        (!pin_sync[2] && pin_sync[1]); // [RQ21]

    // Internal count clock divider
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run_bit || int_tick)
            div_cnt <= 16'h0000;
        else
            div_cnt <= div_cnt + 16'h0001;
    end
    assign int_tick = (div_cnt == 16'(CLK_DIV - 1));

    // Event mode and enabled external counting use input edges
    assign tick = (interval_mode && !external_event_enable) ? int_tick : ev_edge;

    // ----------------------------------------
    // Counter, buffers and match logic
    // ----------------------------------------
    logic zero_hit;
    logic one_hit;
    assign zero_hit = started && tick && (count == compare_buffer_zero);
    assign one_hit = started && tick && (count == compare_buffer_one);

    // Counter clears on start and on match; no overflow in these modes
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run_bit)
        begin
            count <= iect_pkg::CNT_STOP;
            started <= 1'b0;
        end
        else if (!started && (event_mode || tick))
        begin
            count <= iect_pkg::CNT_ZERO; // [RQ9] [RQ12] [RQ18]
            started <= 1'b1;
        end
        else if (zero_hit)
            count <= iect_pkg::CNT_ZERO; // [RQ1] [RQ3] [RQ4] [RQ13] [RQ19]
        else if (started && tick)
            count <= count + 16'h0001; // [RQ5]
    end

    // Buffers follow the registers one clock behind, so a start loads them too
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            compare_buffer_zero <= iect_pkg::CMP_RST;
            compare_buffer_one <= iect_pkg::CMP_RST;
        end
        else
        begin
            compare_buffer_zero <= compare_reg_zero; // [RQ5] [RQ12] [RQ18]
            compare_buffer_one <= compare_reg_one; // [RQ2] [RQ16]
        end
    end

    // Match requests and square-wave outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            zero_match_request <= 1'b0;
            one_match_request <= 1'b0;
            output_zero <= 1'b0;
            output_one <= 1'b0;
        end
        else
        begin
            zero_match_request <= zero_hit; // [RQ13] [RQ19]
            one_match_request <= one_hit; // [RQ2] [RQ8] [RQ16]
            if (interval_mode && run_bit && !started && tick)
                output_zero <= !output_zero; // [RQ18]
            else if (interval_mode && zero_hit)
                output_zero <= !output_zero; // [RQ3] [RQ19]
            if (interval_mode && one_hit)
                output_one <= !output_one; // [RQ7] [RQ10] [RQ14]
        end
    end

    // Overflow request is never raised in interval or event count mode
    assign overflow_request = 1'b0; // [RQ4]

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_STOP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ18]
        !run_bit |=> count == iect_pkg::CNT_STOP)
        else $error("Stopped counter is not FFFFH");
    AST_EVENT_START: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ12]
        run_bit && !started && event_mode |=> count == CNT0 && started)
        else $error("Event mode start did not clear counter");
    AST_ZERO_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ19]
        zero_hit && run_bit |=> count == CNT0 && zero_match_request)
        else $error("Zero match did not clear counter and request");
    AST_OUT0_TOGGLE: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ19]
        zero_match_request && $past(interval_mode) |-> output_zero != $past(output_zero))
        else $error("Output zero not toggled on zero match");
    AST_ONE_CAUSE: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ8]
        one_match_request |-> $past(count) == $past(compare_buffer_one) && $past(tick))
        else $error("One match request without equality");
    AST_OUT1_EVENT: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ14]
        event_mode && $past(event_mode) |-> $stable(output_one) && $stable(output_zero))
        else $error("Output changed in event count mode");
    AST_BUF0_WRITE: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ5]
        wr_fire && aw_addr == iect_pkg::CMP0_OFS |=> ##2 compare_buffer_zero == compare_reg_zero)
        else $error("Compare zero write not buffered");
    AST_EDGE_ONCE: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ21]
        ev_edge |=> !ev_edge)
        else $error("Edge counted twice");
    AST_WRAP_NO_OVF: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ4]
        zero_hit && count == iect_pkg::CNT_STOP |=> zero_match_request && !overflow_request)
        else $error("FFFFH match misbehaved");

    COV_ZERO_MATCH: cover property (@(posedge aclk) disable iff (!aresetn)
        zero_match_request && interval_mode);
    COV_ONE_MATCH: cover property (@(posedge aclk) disable iff (!aresetn)
        one_match_request && output_one);
    COV_EVENT: cover property (@(posedge aclk) disable iff (!aresetn)
        zero_match_request && event_mode);
endmodule

`default_nettype wire

/* File: iect_pkg.sv */
// Constants and types for the interval and event count timer channel.
// Assumes a single 100 MHz clock and an AXI4-Lite register bus.
`default_nettype none

package iect_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CMP0_OFS = 8'h04;
    localparam logic [7:0] CMP1_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    // Control field positions
    localparam int RUN_POS = 0;
    localparam int MODE_LSB = 1;
    localparam int EEE_POS = 4;
    localparam int FALL_POS = 5;
    localparam logic [5:0] CTRL_RST = 6'h00;
    // Counter values
    localparam logic [15:0] CNT_STOP = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam int CLK_DIV = 1;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Operating modes of the mode field
    typedef enum logic [2:0] {
        IECT_INTERVAL = 3'h0,
        IECT_EVENT = 3'h1
    } iect_mode_e;
endpackage

`default_nettype wire

/* File: iect_event_src.sv */
// Partner model: external event source on the count input pin.
// Assumes the bench raises fire for one clock while the source is idle.
`default_nettype none
module iect_event_src (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic fire,
    input wire logic slow,
    output logic pin,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // One rising edge per request; the low tail lets the synchroniser settle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt <= 4'h0;
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
        else if (fire)
            cnt <= slow ? 4'hf : 4'h8;
    end
    assign pin = (cnt > 4'h4); // High first, then low four clocks
    assign busy = (cnt != 4'h0) | fire;
endmodule
`default_nettype wire

/* File: iect_timer_tb_top.sv */
// Self-checking bench for the timer channel over AXI4-Lite.
// Assumes the iect_timer design and the iect_event_src partner.
`default_nettype none
module iect_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, out0, out1, zreq, oreq, ovreq;
    logic [1:0] bresp, rresp, r;
    logic fire = 1'b0, slow = 1'b0, pin, busy, p1 = 1'b0;
    int n_mismatch = 0, n_tests = 0, cyc = 0, nz = 0, no = 0, t1 = 0;
    iect_timer #(.CLK_DIV(1)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .event_input_pin(pin), .output_zero(out0), .output_one(out1),
        .zero_match_request(zreq), .one_match_request(oreq), .overflow_request(ovreq)
    );
    iect_event_src src (.aclk(aclk), .aresetn(aresetn), .fire(fire), .slow(slow), .pin(pin),
        .busy(busy));
    // 100 MHz clock
    initial forever #5 aclk = ~aclk;
    // Mid-cycle tallies of pulses and toggles, plus the hang limit
    always @(negedge aclk)
    begin
        nz <= nz + int'(zreq === 1'b1);
        no <= no + int'(oreq === 1'b1);
        t1 <= t1 + int'(out1 !== p1);
        p1 <= out1;
        cyc <= cyc + 1;
        if (aresetn) chk(ovreq, 0);
        if (cyc == 90000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Write one word; both channels offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_w, w_w;
        aw_w = 1'b1;
        w_w = 1'b1;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_w | w_w)
        begin
            @(negedge aclk);
            aw_w = aw_w & (awready !== 1'b1);
            w_w = w_w & (wready !== 1'b1);
            @(posedge aclk);
            awvalid <= aw_w;
            wvalid <= w_w;
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        chk(bresp, iect_pkg::RESP_OKAY);
        // Response taken at this edge; bready stays high between writes
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        // Data taken at this edge; rready stays high between reads
        @(posedge aclk);
    endtask
    task automatic gap(input logic one, output int n);
        n = 0;
        do
        begin
            @(negedge aclk);
            n++;
        end while (((one ? oreq : zreq) !== 1'b1) && n < 70000);
    endtask
    task automatic edge_in(input logic s);
        fire <= 1'b1;
        slow <= s;
        @(posedge aclk);
        fire <= 1'b0;
        do @(negedge aclk); while (busy === 1'b1);
        @(posedge aclk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_reset();
        rd(iect_pkg::COUNT_OFS);
        chk(d, 0);
        rd(iect_pkg::CMP0_OFS);
        chk(d, 0);
        rd(8'h20);
        chk(r, iect_pkg::RESP_SLVERR);
        chk({out0, out1, zreq, oreq}, 0);
    endtask
    task automatic sc_interval();
        int n, t;
        logic o;
        wr(iect_pkg::CMP0_OFS, 3);
        wr(iect_pkg::CMP1_OFS, 1);
        o = out0;
        wr(iect_pkg::CTRL_OFS, 1);
        @(negedge aclk);
        chk(out0, !o);
        gap(0, n);
        gap(0, n);
        chk(n, 4);
        o = out0;
        gap(0, n);
        chk(out0, !o);
        gap(1, n);
        t = t1;
        gap(1, n);
        chk(n, 4);
        chk(t1 - t, 1);
        @(posedge aclk);
        rd(iect_pkg::COUNT_OFS);
        chk(d >> 2, 0);
        wr(iect_pkg::CTRL_OFS, 0);
    endtask
    task automatic sc_zero();
        int k;
        wr(iect_pkg::CMP0_OFS, 0);
        wr(iect_pkg::CTRL_OFS, 1);
        rd(iect_pkg::COUNT_OFS);
        chk(d, 0);
        @(negedge aclk);
        k = nz;
        repeat (8) @(negedge aclk);
        chk(nz - k, 8);
        @(posedge aclk);
        wr(iect_pkg::CTRL_OFS, 0);
    endtask
    task automatic sc_high();
        int k, t;
        wr(iect_pkg::CMP0_OFS, 3);
        wr(iect_pkg::CMP1_OFS, 5);
        k = no;
        t = t1;
        wr(iect_pkg::CTRL_OFS, 1);
        repeat (30) @(posedge aclk);
        chk(no - k, 0);
        chk(t1 - t, 0);
        wr(iect_pkg::CTRL_OFS, 0);
    endtask
    task automatic sc_event();
        int k, j, t;
        logic o;
        wr(iect_pkg::CMP0_OFS, 2);
        wr(iect_pkg::CMP1_OFS, 1);
        o = out0;
        t = t1;
        k = nz;
        j = no;
        wr(iect_pkg::CTRL_OFS, 6'h03);
        repeat (2) @(posedge aclk);
        rd(iect_pkg::COUNT_OFS);
        chk(d, 0);
        edge_in(1'b1);
        rd(iect_pkg::COUNT_OFS);
        chk(d, 1);
        for (int i = 0; i < 5; i++) edge_in(i[0]);
        chk(nz - k, 2);
        chk(no - j, 2);
        chk(out0, o);
        chk(t1 - t, 0);
        wr(iect_pkg::CTRL_OFS, 0);
    endtask
    task automatic sc_ext();
        int t;
        wr(iect_pkg::CMP0_OFS, 1);
        wr(iect_pkg::CMP1_OFS, 1);
        // Falling edges counted here; rising ones are covered in event mode
        wr(iect_pkg::CTRL_OFS, 6'h31);
        repeat (4) @(posedge aclk);
        rd(iect_pkg::COUNT_OFS);
        chk(d, 16'hffff);
        edge_in(1'b0);
        rd(iect_pkg::COUNT_OFS);
        chk(d, 0);
        t = t1;
        repeat (4) edge_in(1'b1);
        chk(t1 - t, 2);
        wr(iect_pkg::CTRL_OFS, 0);
    endtask
    task automatic sc_rewrite();
        int n, c0;
        wr(iect_pkg::CMP0_OFS, 16'h40);
        wr(iect_pkg::CTRL_OFS, 1);
        gap(0, n);
        c0 = cyc;
        @(posedge aclk);
        wr(iect_pkg::CMP0_OFS, 2);
        gap(0, n);
        chk(cyc - c0, 32'h10003);
        @(posedge aclk);
        wr(iect_pkg::CTRL_OFS, 0);
    endtask
    // Main sequence
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        sc_reset();
        sc_interval();
        sc_zero();
        sc_high();
        sc_event();
        sc_ext();
        sc_rewrite();
        tally_and_finish();
    end
endmodule
`default_nettype wire
